// ---- hw/anp_regs_defs.svh ----
// Constants of the auto-negotiation next-page register bank.
// Included by the bank's design file only; definitions only.
`ifndef ANP_REGS_DEFS_SVH
`define ANP_REGS_DEFS_SVH

// Register indexes; byte address is four times the index
`define ANP_IDX_EXP 4'h6
`define ANP_IDX_NPTX 4'h7
`define ANP_IDX_LPNP 4'h8
`define ANP_IDX_GCTL 4'h9
`define ANP_IDX_INT_STAT 4'hA
`define ANP_IDX_INT_MASK 4'hB

// Field positions
`define ANP_BIT_NP 15
`define ANP_BIT_ACK 14
`define ANP_BIT_MP 13
`define ANP_BIT_ACK2 12
`define ANP_BIT_TOG 11
`define ANP_BIT_MSE 12
`define ANP_TM_HI 15
`define ANP_TM_LO 13

// Reset values
`define ANP_NPTX_RST 16'h2001
`define ANP_LPNP_RST 16'h0000
`define ANP_LOCAL_NP_RST 1'h1
`define ANP_TM_RST 3'h0
`define ANP_MSE_RST 1'h0

// Interrupt event bits
`define ANP_EV_FAULT 0
`define ANP_EV_PAGE 1
`define ANP_EV_W 2

`endif

// ---- hw/anp_regs_pkg.sv ----
// Types of the auto-negotiation next-page register bank.
// Used by fully qualified name; nothing is imported.
package anp_regs_pkg;
  // Gigabit test-mode field encodings
  typedef enum logic [2:0] {
    ANP_TM_NORMAL = 3'h0,
    ANP_TM_WAVEFORM = 3'h1,
    ANP_TM_JIT_MASTER = 3'h2,
    ANP_TM_JIT_SLAVE = 3'h3,
    ANP_TM_DISTORT = 3'h4
  } anp_test_mode_t;

  // APB slave phases
  typedef enum logic [1:0] {
    ANP_BUS_IDLE,
    ANP_BUS_SETUP,
    ANP_BUS_ACCESS
  } anp_bus_state_t;
endpackage : anp_regs_pkg

// ---- hw/anp_regs.sv ----
// Auto-negotiation expansion, next-page and gigabit control registers,
// APB slave with a sticky event interrupt.
// Assumes one 100 MHz clock; auto-negotiation engine inputs are synchronous.
//
// Summary of operation
// - Expansion bits 15:5 always read zero
// - Expansion low bits valid after negotiation completes
// - Parallel-detect fault latches expansion bit 4
// - New received page latches expansion bit 1
// - Bit 3 shows partner next-page ability
// - Bit 2 local next-page ability, resets one
// - Bit 0 shows partner auto-negotiation ability
// - Transmit word write pulses page-loaded flag
// - Link failure clears transmit word to reset
// - Transmit word writable fields; 14, 11 read-only
// - Partner word presents received code word
// - Test-mode field selects normal or four test modes
// - Jitter tests take transmit clock from receive
// - Restart clears test mode; soft reset keeps
// - Bit 12 selects manual master/slave
// - Manual enable applies on reset, restart, link
// - Reading latch-high bits clears them
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "anp_regs_defs.svh"

module anp_regs (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Auto-negotiation engine
  input wire logic soft_reset_in,
  input wire logic an_restart_in,
  input wire logic power_up_in,
  input wire logic link_fail_in,
  input wire logic an_complete_in,
  input wire logic pd_fault_in,
  input wire logic page_rx_in,
  input wire logic [15:0] rx_word_in,
  input wire logic partner_an_able_in,
  input wire logic page_sent_in,
  output logic page_loaded_out,
  output logic [15:0] tx_word_out,
  output logic [2:0] test_mode_out,
  output logic tx_clk_from_rx_out,
  output logic manual_ms_out,
  output logic irq_out
);

  // State
  anp_regs_pkg::anp_bus_state_t bus_q;
  logic [15:0] nptx_q;
  logic [15:0] lpnp_q;
  logic fault_q;
  logic page_q;
  logic lp_np_q;
  logic local_np_q;
  logic lp_an_q;
  logic toggle_q;
  logic [2:0] tm_q;
  logic mse_q;
  logic mse_act_q;
  logic [`ANP_EV_W-1:0] ist_q;
  logic [`ANP_EV_W-1:0] imask_q;
  logic [31:0] rdata_q;
  logic ready_q;
  logic err_q;
  logic loaded_q;
  logic irq_q;

  // Address decode
  wire acc = psel_in && penable_in && (bus_q == anp_regs_pkg::ANP_BUS_ACCESS);
  wire [5:0] idx = paddr_in[7:2];
  wire hit_exp = idx == {2'h0, `ANP_IDX_EXP};
  wire hit_nptx = idx == {2'h0, `ANP_IDX_NPTX};
  wire hit_lpnp = idx == {2'h0, `ANP_IDX_LPNP};
  wire hit_gctl = idx == {2'h0, `ANP_IDX_GCTL};
  wire hit_ist = idx == {2'h0, `ANP_IDX_INT_STAT};
  wire hit_imsk = idx == {2'h0, `ANP_IDX_INT_MASK};
  wire mapped = hit_exp | hit_nptx | hit_lpnp | hit_gctl | hit_ist | hit_imsk;
  wire wr = acc && pwrite_in && mapped;
  wire rd = acc && !pwrite_in && mapped;
  wire wr_nptx = wr && hit_nptx;
  wire wr_gctl = wr && hit_gctl;
  wire rd_exp = rd && hit_exp;
  wire rd_ist = rd && hit_ist;
  wire apply_ms = soft_reset_in | an_restart_in | power_up_in | link_fail_in;
  // Written fields as seen on the bus, for the checks
  wire [2:0] wr_tm = pwdata_in[`ANP_TM_HI:`ANP_TM_LO];
  wire wr_mse = pwdata_in[`ANP_BIT_MSE];
  wire [15:0] wr_half = pwdata_in[15:0];

  // Expansion word, reserved upper bits zero
  wire [15:0] exp_word = {11'h000, fault_q, lp_np_q, local_np_q, page_q, lp_an_q};

  // Transmit word: writable fields plus internal toggle and reserved
  wire [15:0] nptx_wr = {pwdata_in[`ANP_BIT_NP], 1'h0, pwdata_in[`ANP_BIT_MP],
                         pwdata_in[`ANP_BIT_ACK2], 1'h0, pwdata_in[10:0]};
  wire [15:0] nptx_rd = {nptx_q[15:12], toggle_q, nptx_q[10:0]};

  wire [15:0] gctl_word = {tm_q, mse_q, 12'h000};
  wire [`ANP_EV_W-1:0] ev = {page_rx_in, pd_fault_in};
  wire [31:0] rd_mux = hit_exp ? {16'h0000, exp_word} :
                       hit_nptx ? {16'h0000, nptx_rd} :
                       hit_lpnp ? {16'h0000, lpnp_q} :
                       hit_gctl ? {16'h0000, gctl_word} :
                       hit_ist ? {30'h0, ist_q} :
                       {30'h0, imask_q};
  wire [2:0] tm_next = an_restart_in ? `ANP_TM_RST : (wr_gctl ? pwdata_in[15:13] : tm_q);
  wire jit = (tm_q == anp_regs_pkg::ANP_TM_JIT_MASTER) ||
             (tm_q == anp_regs_pkg::ANP_TM_JIT_SLAVE);

  // APB phase tracking; one wait-free access cycle
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_q <= anp_regs_pkg::ANP_BUS_IDLE;
      ready_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en_in) begin
      if (psel_in && !penable_in) begin
        bus_q <= anp_regs_pkg::ANP_BUS_ACCESS;
      end else if (acc) begin
        bus_q <= anp_regs_pkg::ANP_BUS_IDLE;
      end
      ready_q <= psel_in && !penable_in;
      err_q <= psel_in && !penable_in && !mapped;
      rdata_q <= (psel_in && !penable_in && !pwrite_in && mapped) ? rd_mux : 32'h0000_0000;
    end
  end

  // Expansion latches and partner status
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_q <= 1'b0;
      page_q <= 1'b0;
      lp_np_q <= 1'b0;
      lp_an_q <= 1'b0;
      local_np_q <= `ANP_LOCAL_NP_RST;
    end else if (clk_en_in) begin
      fault_q <= pd_fault_in | (fault_q & ~rd_exp);
      page_q <= page_rx_in | (page_q & ~rd_exp);
      if (soft_reset_in) begin
        lp_np_q <= 1'b0;
        lp_an_q <= 1'b0;
        local_np_q <= `ANP_LOCAL_NP_RST;
      end else if (an_complete_in) begin
        lp_np_q <= lpnp_q[`ANP_BIT_NP] | lp_np_q;
        lp_an_q <= partner_an_able_in;
      end
    end
  end

  // Partner next-page word capture
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lpnp_q <= `ANP_LPNP_RST;
    end else if (clk_en_in) begin
      if (soft_reset_in) begin
        lpnp_q <= `ANP_LPNP_RST;
      end else if (page_rx_in) begin
        lpnp_q <= rx_word_in;
      end
    end
  end

  // Transmit word, page-loaded pulse and toggle
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nptx_q <= `ANP_NPTX_RST;
      loaded_q <= 1'b0;
      toggle_q <= 1'b0;
    end else if (clk_en_in) begin
      loaded_q <= wr_nptx;
      if (link_fail_in || soft_reset_in) begin
        nptx_q <= `ANP_NPTX_RST;
        toggle_q <= 1'b0;
      end else begin
        if (wr_nptx) begin
          nptx_q <= nptx_wr;
        end
        if (page_sent_in) begin
          toggle_q <= ~toggle_q;
        end
      end
    end
  end

  // Gigabit control: test mode and manual master/slave enable
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tm_q <= `ANP_TM_RST;
      mse_q <= `ANP_MSE_RST;
      mse_act_q <= `ANP_MSE_RST;
    end else if (clk_en_in) begin
      tm_q <= tm_next;
      if (wr_gctl) begin
        mse_q <= pwdata_in[`ANP_BIT_MSE];
      end
      if (apply_ms) begin
        mse_act_q <= wr_gctl ? pwdata_in[`ANP_BIT_MSE] : mse_q;
      end
    end
  end

  // Sticky interrupt status, mask and line
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ist_q <= '0;
      imask_q <= '0;
      irq_q <= 1'b0;
    end else if (clk_en_in) begin
      ist_q <= ev | (ist_q & {`ANP_EV_W{~rd_ist}});
      if (wr && hit_imsk) begin
        imask_q <= pwdata_in[`ANP_EV_W-1:0];
      end
      irq_q <= |((ev | (ist_q & {`ANP_EV_W{~rd_ist}})) & imask_q);
    end
  end

  // Outputs straight from flip-flops
  assign prdata_out = rdata_q;
  assign pready_out = ready_q;
  assign pslverr_out = err_q;
  assign page_loaded_out = loaded_q;
  assign tx_word_out = nptx_rd;
  assign test_mode_out = tm_q;
  assign manual_ms_out = mse_act_q;
  assign irq_out = irq_q;

  // Jitter clock select registered
  logic jit_q;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      jit_q <= 1'b0;
    end else if (clk_en_in) begin
      jit_q <= (tm_next == anp_regs_pkg::ANP_TM_JIT_MASTER) ||
               (tm_next == anp_regs_pkg::ANP_TM_JIT_SLAVE);
    end
  end
  assign tx_clk_from_rx_out = jit_q;

  // Checks; some bus accesses use named sequences, other bus accesses and engine events are written inline
  sequence s_np_write;
    clk_en_in && wr_nptx;
  endsequence

  sequence s_exp_read;
    clk_en_in && rd_exp;
  endsequence

  sequence s_ist_read;
    clk_en_in && rd_ist;
  endsequence

  sequence s_gctl_write;
    clk_en_in && wr_gctl && !an_restart_in;
  endsequence

  a_exp_upper_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    exp_word[15:5] == 11'h000) else $error("expansion reserved bits nonzero");
  a_fault_latch: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && pd_fault_in |=> fault_q) else $error("fault not latched");
  a_page_latch: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && page_rx_in |=> page_q && lpnp_q == $past(rx_word_in))
    else $error("page not latched");
  a_read_clears: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && rd_exp && !page_rx_in |=> !page_q) else $error("read did not clear");
  a_load_pulse: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_np_write |=> page_loaded_out) else $error("no page-loaded pulse");
  a_link_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && link_fail_in |=> nptx_q == `ANP_NPTX_RST) else $error("tx word kept");
  a_restart_tm: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && an_restart_in |=> tm_q == `ANP_TM_RST && !tx_clk_from_rx_out)
    else $error("test mode kept");
  a_ms_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && !apply_ms |=> $stable(manual_ms_out)) else $error("early apply");
  a_jitter_clk: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && jit |=> tx_clk_from_rx_out || $changed(tm_q)) else $error("clock select");

  // Local next-page ability never drops
  a_local_np_one: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    exp_word[2] == `ANP_LOCAL_NP_RST) else $error("local next-page bit low");

  // Reserved transmit bit stays zero
  a_tx_reserved: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !tx_word_out[`ANP_BIT_ACK]) else $error("reserved tx bit set");

  // Writable transmit fields follow the written word
  a_tx_map: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_np_write ##0 !link_fail_in && !soft_reset_in |=>
    (tx_word_out & 16'hB7FF) == ($past(wr_half) & 16'hB7FF))
    else $error("tx word not written");

  // Partner word holds between pages
  a_lpnp_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && !page_rx_in && !soft_reset_in |=> $stable(lpnp_q))
    else $error("partner word moved");

  // Test-mode write lands
  a_tm_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_gctl_write |=> test_mode_out == $past(wr_tm)) else $error("test mode not written");

  // Soft reset keeps test mode
  a_tm_soft_keep: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && soft_reset_in && !an_restart_in && !wr_gctl |=> $stable(tm_q))
    else $error("test mode lost");

  // Manual enable register follows writes
  a_mse_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && wr_gctl |=> mse_q == $past(wr_mse)) else $error("manual enable not stored");

  // Apply event copies stored enable
  a_ms_apply: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && apply_ms && !wr_gctl |=> manual_ms_out == $past(mse_q))
    else $error("manual enable not applied");

  // Interrupt status read clears it
  a_ist_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_ist_read ##0 !(|ev) |=> ist_q == '0) else $error("status not cleared");

  // Expansion read clears the fault latch
  a_fault_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_exp_read ##0 !pd_fault_in |=> !fault_q) else $error("fault not cleared");

  // Page flag stays until read
  a_page_stay: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && page_q && !rd_exp |=> page_q) else $error("page flag lost");

  // Toggle flips per sent page
  a_toggle_flip: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && page_sent_in && !link_fail_in && !soft_reset_in |=>
    toggle_q != $past(toggle_q)) else $error("toggle kept");

  // No page-loaded pulse without a write
  a_load_only: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && !wr_nptx |=> !page_loaded_out) else $error("spurious page-loaded");

  // Partner ability captured at completion
  a_partner_able: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && an_complete_in && !soft_reset_in |=> exp_word[0] == $past(partner_an_able_in))
    else $error("partner ability wrong");

  // Partner next-page ability set from received word
  a_lp_np_set: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && an_complete_in && !soft_reset_in && lpnp_q[`ANP_BIT_NP] |=> lp_np_q)
    else $error("partner next-page not set");

  // Frozen clock enable holds the test mode
  a_freeze_tm: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !clk_en_in |=> $stable(tm_q)) else $error("state moved while frozen");

endmodule : anp_regs

// ---- tb/anp_partner_model.sv ----
// Stand-in for the negotiation engine and remote partner feeding the bank.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module anp_partner_model (
  input wire logic clk_in,
  output logic an_complete_out,
  output logic pd_fault_out,
  output logic page_rx_out,
  output logic [15:0] rx_word_out,
  output logic partner_an_able_out,
  output logic page_sent_out
);
  // Idle levels; the word line carries junk between pages
  initial begin
    {an_complete_out, pd_fault_out, page_rx_out, partner_an_able_out, page_sent_out} = '0;
    rx_word_out = 16'h5A5A;
  end
  // Completion and partner ability levels
  task automatic status(input logic [1:0] s);
    {an_complete_out, partner_an_able_out} <= s;
  endtask : status
  // One received page; word valid only with its strobe
  task automatic send_page(input logic [15:0] w);
    {page_rx_out, rx_word_out} <= {1'b1, w};
    @(posedge clk_in);
    {page_rx_out, rx_word_out} <= {1'b0, ~w};
  endtask : send_page
  // One-cycle fault or page-sent strobe
  task automatic strobe(input logic fault);
    {pd_fault_out, page_sent_out} <= {fault, ~fault};
    @(posedge clk_in);
    {pd_fault_out, page_sent_out} <= 2'b00;
  endtask : strobe
endmodule : anp_partner_model

// ---- tb/tb_anp_regs.sv ----
// Self-checking bench for the next-page register bank.
// Assumes APB answers within 20 access cycles and the partner model beside the bank.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb_anp_regs;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, cen = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, done, flt, prx, able, sent, loaded, txclk, manual, irq;
  logic [3:0] ev = 4'h0;
  logic [15:0] rxw, txw;
  logic [2:0] tmode;
  int failures = 0, checks_done = 0, loads = 0;
  always #5 clk = ~clk;
  // Counts page-loaded pulses
  always @(posedge clk) if (loaded === 1'b1) loads++;
  anp_regs i_dut (.clk_in(clk), .reset_n_in(rst_n), .clk_en_in(cen), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .soft_reset_in(ev[0]), .an_restart_in(ev[1]), .power_up_in(ev[2]),
    .link_fail_in(ev[3]), .an_complete_in(done), .pd_fault_in(flt), .page_rx_in(prx),
    .rx_word_in(rxw), .partner_an_able_in(able), .page_sent_in(sent),
    .page_loaded_out(loaded), .tx_word_out(txw), .test_mode_out(tmode),
    .tx_clk_from_rx_out(txclk), .manual_ms_out(manual), .irq_out(irq));
  anp_partner_model i_peer (.clk_in(clk), .an_complete_out(done), .pd_fault_out(flt),
    .page_rx_out(prx), .rx_word_out(rxw), .partner_an_able_out(able), .page_sent_out(sent));
  // APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    repeat (20) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    `CHK(pready, 1'b1)
    {psel, pen} <= 2'b00;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d});
  endtask : wr
  task automatic rdc(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rdc
  // Event pulses: soft reset, restart, power up, link fail
  task automatic pulse(input logic [3:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    @(posedge clk);
  endtask : pulse
  task automatic t_reset;
    `CHK(txw, 16'h2001)
    rdc(8'h18); `CHK(rd, 32'h4)
    rdc(8'h1C); `CHK(rd, 32'h2001)
    rdc(8'h20); `CHK(rd, 32'h0)
    rdc(8'h24); `CHK(rd, 32'h0)
    rdc(8'h3C); `CHK({err, rd}, 33'h100000000)
  endtask : t_reset
  task automatic t_nptx;
    wr(8'h1C, 16'hFFFF);
    rdc(8'h1C); `CHK(rd, 32'hB7FF)
    `CHK(loads, 1)
    `CHK(txw, 16'hB7FF)
    i_peer.strobe(1'b0);
    @(posedge clk);
    `CHK(txw[11], 1'b1)
    pulse(4'h8);
    rdc(8'h1C); `CHK(rd & 32'hF7FF, 32'h2001)
  endtask : t_nptx
  task automatic t_page;
    i_peer.status(2'b11);
    i_peer.send_page(16'hA123);
    rdc(8'h20); `CHK(rd, 32'hA123)
    `CHK(irq, 1'b0)
    rdc(8'h18); `CHK(rd, 32'hF)
    rdc(8'h18); `CHK(rd, 32'hD)
    rdc(8'h28); `CHK(rd, 32'h2)
    rdc(8'h28); `CHK({irq, rd}, 33'h0)
    wr(8'h2C, 16'h3);
    i_peer.strobe(1'b1);
    rdc(8'h18); `CHK(rd, 32'h1D)
    rdc(8'h28); `CHK({irq, rd}, 33'h1)
    i_peer.status(2'b00);
  endtask : t_page
  // Fault strobe while frozen must not latch
  task automatic t_freeze;
    cen <= 1'b0;
    i_peer.strobe(1'b1);
    cen <= 1'b1;
    rdc(8'h18); `CHK({irq, rd}, 33'hD)
  endtask : t_freeze
  task automatic t_test;
    for (int c = 0; c < 5; c++) begin
      wr(8'h24, {c[2:0], 13'h0});
      `CHK({tmode, txclk}, {c[2:0], c[2:1] == 2'b01})
    end
    pulse(4'h1); `CHK(tmode, 3'h4)
    pulse(4'h2); `CHK(tmode, 3'h0)
    pulse(4'h1);
    rdc(8'h24); `CHK(rd, 32'h0)
  endtask : t_test
  task automatic t_manual;
    for (int i = 0; i < 4; i++) begin
      wr(8'h24, {3'h0, ~i[0], 12'h0});
      `CHK(manual, i[0])
      pulse(4'h1 << i);
      `CHK(manual, ~i[0])
    end
  endtask : t_manual
  task automatic final_report;
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_nptx;
    t_page;
    t_freeze;
    t_test;
    t_manual;
    final_report;
  end
  // Watchdog
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    final_report;
  end
endmodule : tb_anp_regs
